// file: pkg/gpio_port_defines.vh
// Notes on behaviour
// - Six general purpose pins, one bit each in every port register.
// - Writing one to an output-high bit drives that pin output high.
// - Zero bits written to the output-high register leave outputs unchanged.
// - Writing one to an output-low bit drives output low; zero does nothing.
// - Pin-level monitor reads present pin levels; writes to it are ignored.
// - Direction bit zero means input, one means output; all clear on reset.
// - Edge-seen flags hold, per pin, that an enabled edge was detected.
// - Rising-edge enable bit one makes low-to-high transitions detected.
// - Falling-edge enable bit one makes high-to-low transitions detected.
// - Every detected enabled edge sets that pin's edge-seen flag.
// - Function-select zero routes pin to alternate function, one to I/O.
// - After power-up reset every pin is an input; pins 0-3 select I/O, pins 4 and 5 the alternate function.
// - Internal power-on reset holds the block in reset until I/O supply valid.
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH

`define ADDR_OUTPUT_HIGH_WRITE    8'h10
`define ADDR_OUTPUT_LOW_WRITE     8'h11
`define ADDR_PIN_LEVEL_MONITOR    8'h12
`define ADDR_PIN_DIRECTION        8'h13
`define ADDR_EDGE_SEEN_FLAGS      8'h14
`define ADDR_RISING_EDGE_ENABLE   8'h15
`define ADDR_FALLING_EDGE_ENABLE  8'h16
`define ADDR_PIN_FUNCTION_SELECT  8'h17

`define RST_OUTPUT_LEVEL          8'h00
`define RST_PIN_DIRECTION         8'h00
`define RST_EDGE_ENABLE           8'h00
`define RST_EDGE_FLAGS            8'h00
`define RST_PIN_FUNCTION_SELECT   8'h0f

`define PIN_COUNT                 6

`endif

// file: core/pin_sync_edge.v
`timescale 1ns/100ps
`default_nettype none

module pin_sync_edge #(
    parameter WIDTH = 6
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] pin_async,
    output reg  [WIDTH-1:0] level_q,
    output reg  [WIDTH-1:0] prev_q
);

    reg [WIDTH-1:0] meta_q;

    // Two-stage synchroniser, then one more stage for edge history
    always @(posedge clk) begin
        if (rst) begin
            meta_q  <= {WIDTH{1'b0}};
            level_q <= {WIDTH{1'b0}};
            prev_q  <= {WIDTH{1'b0}};
        end else begin
            meta_q  <= pin_async;
            level_q <= meta_q;
            prev_q  <= level_q;
        end
    end

endmodule

`default_nettype wire

// file: core/gpio_port.v
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_defines.vh"

module gpio_port #(
    parameter NPIN = `PIN_COUNT
) (
    input  wire            CLK_SYS,
    input  wire            RST,
    input  wire            POR_SUPPLY_VALID,
    input  wire            REG_WR,
    input  wire            REG_RD,
    input  wire [7:0]      REG_ADDR,
    input  wire [7:0]      REG_WDATA,
    output reg  [7:0]      REG_RDATA,
    output reg             REG_RVALID,
    input  wire [NPIN-1:0] PIN_IN,
    output reg  [NPIN-1:0] PIN_OUT,
    output reg  [NPIN-1:0] PIN_OE,
    output reg  [NPIN-1:0] PIN_GPIO_MODE
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset: external reset or supply not yet valid

    reg            sup_meta_q;
    reg            sup_ok_q;
    wire           rst_all;

    always @(posedge CLK_SYS) begin
        if (RST) begin
            sup_meta_q <= 1'b0;
            sup_ok_q   <= 1'b0;
        end else begin
            sup_meta_q <= POR_SUPPLY_VALID;
            sup_ok_q   <= sup_meta_q;
        end
    end

    assign rst_all = RST | ~sup_ok_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin input synchronisation

    wire [NPIN-1:0] level_now;
    wire [NPIN-1:0] level_prev;

    pin_sync_edge #(
        .WIDTH (NPIN)
    ) u_sync (
        .clk       (CLK_SYS),
        .rst       (rst_all),
        .pin_async (PIN_IN),
        .level_q   (level_now),
        .prev_q    (level_prev)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    reg  [NPIN-1:0] out_q;
    reg  [NPIN-1:0] out_d;
    reg  [NPIN-1:0] dir_q;
    reg  [NPIN-1:0] rise_en_q;
    reg  [NPIN-1:0] fall_en_q;
    reg  [NPIN-1:0] func_q;
    reg  [NPIN-1:0] flags_q;
    reg  [NPIN-1:0] flags_d;
    reg  [NPIN-1:0] edge_hit;
    reg  [NPIN-1:0] clr_mask;
    reg  [7:0]      rdata_d;
    reg  [1:0]      fill_q;

    localparam [7:0] RST_OUT   = `RST_OUTPUT_LEVEL;
    localparam [7:0] RST_DIR   = `RST_PIN_DIRECTION;
    localparam [7:0] RST_EDGE  = `RST_EDGE_ENABLE;
    localparam [7:0] RST_FLAGS = `RST_EDGE_FLAGS;
    localparam [7:0] RST_FUNC  = `RST_PIN_FUNCTION_SELECT;

    wire wr_high  = REG_WR && (REG_ADDR == `ADDR_OUTPUT_HIGH_WRITE);
    wire wr_low   = REG_WR && (REG_ADDR == `ADDR_OUTPUT_LOW_WRITE);
    wire wr_dir   = REG_WR && (REG_ADDR == `ADDR_PIN_DIRECTION);
    wire wr_flags = REG_WR && (REG_ADDR == `ADDR_EDGE_SEEN_FLAGS);
    wire wr_rise  = REG_WR && (REG_ADDR == `ADDR_RISING_EDGE_ENABLE);
    wire wr_fall  = REG_WR && (REG_ADDR == `ADDR_FALLING_EDGE_ENABLE);
    wire wr_func  = REG_WR && (REG_ADDR == `ADDR_PIN_FUNCTION_SELECT);
    // Edge history is valid only once the synchroniser has refilled after reset
    wire hist_ok  = (fill_q == 2'd3);

    // Output level update: set and clear writes touch only their one bits
    always @* begin
        out_d = out_q;
        if (wr_high) begin
            out_d = out_q | REG_WDATA[NPIN-1:0];
        end else if (wr_low) begin
            out_d = out_q & ~REG_WDATA[NPIN-1:0];
        end
    end

    // Per-pin edge detection and flag update
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_edge
            always @* begin
                edge_hit[g] = hist_ok
                            & ((rise_en_q[g] & level_now[g] & ~level_prev[g])
                            | (fall_en_q[g] & ~level_now[g] & level_prev[g]));
                clr_mask[g] = wr_flags & REG_WDATA[g];
                if (edge_hit[g]) begin
                    flags_d[g] = 1'b1;
                end else if (clr_mask[g]) begin
                    flags_d[g] = 1'b0;
                end else begin
                    flags_d[g] = flags_q[g];
                end
            end
        end
    endgenerate

    always @(posedge CLK_SYS) begin
        if (rst_all) begin
            out_q     <= RST_OUT[NPIN-1:0];
            dir_q     <= RST_DIR[NPIN-1:0];
            rise_en_q <= RST_EDGE[NPIN-1:0];
            fall_en_q <= RST_EDGE[NPIN-1:0];
            func_q    <= RST_FUNC[NPIN-1:0];
            flags_q   <= RST_FLAGS[NPIN-1:0];
            fill_q    <= 2'd0;
        end else begin
            out_q   <= out_d;
            flags_q <= flags_d;
            if (!hist_ok) begin
                fill_q <= fill_q + 2'd1;
            end
            if (wr_dir) begin
                dir_q <= REG_WDATA[NPIN-1:0];
            end
            if (wr_rise) begin
                rise_en_q <= REG_WDATA[NPIN-1:0];
            end
            if (wr_fall) begin
                fall_en_q <= REG_WDATA[NPIN-1:0];
            end
            if (wr_func) begin
                func_q <= REG_WDATA[NPIN-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path; monitor register has no write decode

    always @* begin
        rdata_d = 8'h00;
        if (REG_ADDR == `ADDR_OUTPUT_HIGH_WRITE) begin
            rdata_d[NPIN-1:0] = out_q;
        end else if (REG_ADDR == `ADDR_OUTPUT_LOW_WRITE) begin
            // Both set and clear addresses read back the output levels
            rdata_d[NPIN-1:0] = out_q;
        end else if (REG_ADDR == `ADDR_PIN_LEVEL_MONITOR) begin
            rdata_d[NPIN-1:0] = level_now;
        end else if (REG_ADDR == `ADDR_PIN_DIRECTION) begin
            rdata_d[NPIN-1:0] = dir_q;
        end else if (REG_ADDR == `ADDR_EDGE_SEEN_FLAGS) begin
            rdata_d[NPIN-1:0] = flags_q;
        end else if (REG_ADDR == `ADDR_RISING_EDGE_ENABLE) begin
            rdata_d[NPIN-1:0] = rise_en_q;
        end else if (REG_ADDR == `ADDR_FALLING_EDGE_ENABLE) begin
            rdata_d[NPIN-1:0] = fall_en_q;
        end else if (REG_ADDR == `ADDR_PIN_FUNCTION_SELECT) begin
            rdata_d[NPIN-1:0] = func_q;
        end
    end

    always @(posedge CLK_SYS) begin
        if (rst_all) begin
            REG_RDATA     <= 8'h00;
            REG_RVALID    <= 1'b0;
            PIN_OUT       <= {NPIN{1'b0}};
            PIN_OE        <= {NPIN{1'b0}};
            PIN_GPIO_MODE <= RST_FUNC[NPIN-1:0];
        end else begin
            REG_RVALID    <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rdata_d;
            end
            PIN_OUT       <= out_d;
            PIN_OE        <= dir_q & func_q;
            PIN_GPIO_MODE <= func_q;
        end
    end

endmodule

`default_nettype wire

// file: testbench/gpio_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module gpio_port_checker #(
    parameter NPIN = 6
) (
    input wire logic            CLK_SYS,
    input wire logic            RST,
    input wire logic            POR_SUPPLY_VALID,
    input wire logic            REG_WR,
    input wire logic            REG_RD,
    input wire logic [7:0]      REG_ADDR,
    input wire logic [7:0]      REG_WDATA,
    input wire logic [7:0]      REG_RDATA,
    input wire logic            REG_RVALID,
    input wire logic [NPIN-1:0] PIN_IN,
    input wire logic [NPIN-1:0] PIN_OUT,
    input wire logic [NPIN-1:0] PIN_OE,
    input wire logic [NPIN-1:0] PIN_GPIO_MODE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST || !POR_SUPPLY_VALID);
    wire [NPIN-1:0] wd = REG_WDATA[NPIN-1:0];
    chk_read_valid: assert property (REG_RVALID == $past(REG_RD))
        else $error("read valid late");
    chk_set_high: assert property (REG_WR && REG_ADDR == 8'h10
        |=> PIN_OUT == ($past(PIN_OUT) | $past(wd))) else $error("set wrong");
    chk_clear_low: assert property (REG_WR && REG_ADDR == 8'h11
        |=> PIN_OUT == ($past(PIN_OUT) & ~$past(wd))) else $error("clear wrong");
    chk_dir_enable: assert property (REG_WR && REG_ADDR == 8'h13
        |=> ##1 PIN_OE == ($past(wd, 2) & PIN_GPIO_MODE)) else $error("enable wrong");
    chk_mode_lag: assert property (REG_WR && REG_ADDR == 8'h17
        |=> ##1 PIN_GPIO_MODE == $past(wd, 2)) else $error("mode wrong");
    chk_alt_no_drive: assert property ((PIN_OE & ~PIN_GPIO_MODE) == '0)
        else $error("alt pin driven");
    chk_reset_state: assert property (disable iff (1'b0) RST
        |=> PIN_OE == '0 && PIN_OUT == '0 && PIN_GPIO_MODE == 'h0f) else $error("reset");
    chk_monitor_read: assert property (REG_RD && REG_ADDR == 8'h12 &&
        $past(PIN_IN) == PIN_IN && $past(PIN_IN, 2) == PIN_IN
        |=> REG_RDATA == {{(8-NPIN){1'b0}}, $past(PIN_IN)}) else $error("monitor");
    cover property (REG_WR && REG_ADDR == 8'h10);
    cover property (REG_RVALID && REG_RDATA != 8'h00);
    cover property (PIN_OE != '0);
endmodule
bind gpio_port gpio_port_checker #(.NPIN(NPIN)) u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
    .POR_SUPPLY_VALID(POR_SUPPLY_VALID), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PIN_GPIO_MODE(PIN_GPIO_MODE));
`default_nettype wire

// file: testbench/gpio_pin_world.sv
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_world (
    input wire logic [5:0] out_lvl,
    input wire logic [5:0] oe,
    input wire logic [5:0] ext_lvl,
    output logic     [5:0] pin_lvl
);
    // A driven pin shows its own output, otherwise the outside level
    assign pin_lvl = (oe & out_lvl) | (~oe & ext_lvl);
endmodule
`default_nettype wire

// file: testbench/gpio_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module gpio_port_test;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       por_ok = 1'b1;
    logic       wr_q = 1'b0;
    logic       rd_q = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [5:0] ext = 6'h00;
    wire  [7:0] rdata;
    wire        rvalid;
    wire  [5:0] pin_in, pin_out, pin_oe, pin_mode;
    int         err_count = 0;
    int         tests_run = 0;
    logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f};
    always #5 clk = ~clk;
    gpio_port u_dut (.CLK_SYS(clk), .RST(rst), .POR_SUPPLY_VALID(por_ok), .REG_WR(wr_q),
        .REG_RD(rd_q), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .PIN_GPIO_MODE(pin_mode));
    gpio_pin_world u_pins (.out_lvl(pin_out), .oe(pin_oe), .ext_lvl(ext), .pin_lvl(pin_in));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_q <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_q <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_q <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_q <= 1'b0;
        #1;
        check(rvalid ? rdata : 8'hxx, exp);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        foreach (rst_tab[i]) rd(8'h10 + 8'(i), rst_tab[i]);
        rd(8'h20, 8'h00);
        $display("reset values done");
        wr(8'h10, 8'h05);
        wr(8'h10, 8'h00);
        rd(8'h10, 8'h05);
        wr(8'h11, 8'h01);
        rd(8'h10, 8'h04);
        check({2'b00, pin_out}, 8'h04);
        rd(8'h11, 8'h04);
        $display("set clear done");
        wr(8'h17, 8'h3f);
        wr(8'h13, 8'h3c);
        repeat (3) @(posedge clk);
        check({2'b00, pin_oe}, 8'h3c);
        check({2'b00, pin_mode}, 8'h3f);
        wr(8'h17, 8'h1f);
        repeat (2) @(posedge clk);
        check({2'b00, pin_oe}, 8'h1c);
        check({2'b00, pin_mode}, 8'h1f);
        wr(8'h12, 8'hff);
        rd(8'h12, 8'h04);
        $display("direction done");
        wr(8'h15, 8'h01);
        wr(8'h16, 8'h06);
        ext <= 6'h02;
        repeat (5) @(posedge clk);
        ext <= 6'h01;
        repeat (5) @(posedge clk);
        rd(8'h14, 8'h03);
        wr(8'h14, 8'h01);
        rd(8'h14, 8'h02);
        wr(8'h11, 8'h04);
        repeat (4) @(posedge clk);
        rd(8'h14, 8'h06);
        $display("edge flags done");
        por_ok <= 1'b0;
        repeat (6) @(posedge clk);
        por_ok <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h13, 8'h00);
        rd(8'h17, 8'h0f);
        check({2'b00, pin_oe}, 8'h00);
        $display("supply reset done");
        end_of_test;
    end
endmodule
`default_nettype wire
